// ### rtl/cdr_pkg.sv
// Constants, register map and timing counts for the contactor and ride-through block.
// Assumes a single 125 MHz clock and a plain strobe register port.
package cdr_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned MS_CYCLES = CLK_MHZ * 1000;
  localparam int unsigned FB_TIMEOUT_MS = 100;
  localparam int unsigned HOLD_DELAY_MS = 50;
  localparam int unsigned MAX_DUR_S = 0;
  localparam logic [15:0] RST_FB_TIMEOUT = 16'(FB_TIMEOUT_MS);
  localparam logic [15:0] RST_HOLD_DELAY = 16'(HOLD_DELAY_MS);
  localparam logic [15:0] RST_MAX_DUR_MS = 16'(MAX_DUR_S * 1000);

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FB_TIMEOUT = 8'h04;
  localparam logic [7:0] REG_HOLD_DELAY = 8'h08;
  localparam logic [7:0] REG_DC_CFG = 8'h0c;
  localparam logic [7:0] REG_ACT_PCT = 8'h10;
  localparam logic [7:0] REG_NOM_VOLTS = 8'h14;
  localparam logic [7:0] REG_DYN_FACTOR = 8'h18;
  localparam logic [7:0] REG_MAX_DUR = 8'h1c;
  localparam logic [7:0] REG_SPEED_THR = 8'h20;
  localparam logic [7:0] REG_ACT_VOLTS = 8'h24;
  localparam logic [7:0] REG_STATUS_WORD = 8'h28;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h2c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h30;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CTRL_FB_SRC = 0;
  localparam int unsigned CTRL_SEQ_CFG = 1;
  localparam int unsigned RT_ACTIVE_BIT = 15;
  localparam int unsigned EV_FB_FAULT = 0;
  localparam int unsigned EV_DUR_FAULT = 1;
  localparam int unsigned EV_SPD_FAULT = 2;
  localparam int unsigned EV_RT_ENTER = 3;
  localparam int unsigned NUM_EV = 4;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [1:0] DC_INHIBIT = 2'h0;
  localparam logic [1:0] DC_MAX_ONLY = 2'h1;
  localparam logic [1:0] DC_MIN_ONLY = 2'h2;
  localparam logic [1:0] DC_BOTH = 2'h3;
  localparam logic [1:0] RST_DC_CFG = DC_MAX_ONLY;
  localparam logic [7:0] RST_ACT_PCT = 8'h4c;      // 76 %
  localparam logic [15:0] RST_NOM_VOLTS = 16'h0190; // 400 V
  localparam logic [15:0] RST_DYN_FACTOR = 16'h012c; // 300 %
  localparam logic [15:0] RST_SPEED_THR = 16'h0032; // 50 rpm
  // Root two scaled by 2^10 (1.41406)
  localparam logic [10:0] SQRT2_Q10 = 11'h5a8;
  localparam logic [6:0] PCT_DIV = 7'h64;
endpackage

// ### rtl/cdr_ms_tick.sv
// Millisecond tick generator for all block timers.
// Assumes the 125 MHz system clock.
`default_nettype none
module cdr_ms_tick
  import cdr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick out
  output logic tick
);
  logic [16:0] cnt;

  // Free running divider; one pulse per millisecond
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == 17'(MS_CYCLES - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 17'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/cdr_sync2.sv
// Two flip-flop synchroniser for asynchronous level inputs.
// Assumes inputs come straight from pins.
`default_nettype none
module cdr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### rtl/cdr_top.sv
// Line contactor sequencing and DC-link minimum-voltage ride-through supervision.
// Assumes pins are asynchronous; the DC-link voltage and speed words are sampled
// values from the measurement logic on the same clock.
// Function
// - Close contactor before run, open after hold
// - Ramp-stop off holds drive for holding delay
// - Feedback not following in timeout raises fault
// - Default feedback loops back own drive
// - Safe torque off opens immediately or delayed
// - Config 0 immediate, 1 after hold delay
// - Feedback timeout defaults to 100 ms
// - Holding delay defaults to 50 ms
// - Activation volts = pct x root2 x nominal
// - Nominal supply defaults to 400 V
// - Engage ride-through at activation threshold
// - Line return leaves ride-through immediately
// - Status bit 15 shows ride-through active
// - Overlong ride-through raises fault; zero disables
// - Dynamic factor defaults to 300 percent
//
// Added by the designer: the address map and strobed register access.
`default_nettype none
module cdr_top
  import cdr_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Drive sequence commands (pins)
  input wire logic RUN_REQ,
  input wire logic SAFE_TORQUE_OFF,
  // Contactor
  output logic CONTACTOR_DRIVE,
  input wire logic CONTACTOR_FEEDBACK_PIN,
  // DC link measurement (same clock)
  input wire logic [15:0] DC_LINK_VOLTS,
  input wire logic [15:0] MOTOR_SPEED,
  // Ride-through and faults
  output logic RIDE_THROUGH_ACTIVE,
  output logic [15:0] RIDE_THROUGH_DYN_FACTOR,
  output logic IRQ
);
  // ----------------------------------------
  // Configuration and state
  // ----------------------------------------
  logic contactor_feedback_source;
  logic sequence_config;
  logic [15:0] contactor_feedback_timeout;
  logic [15:0] contactor_holding_delay;
  logic [1:0] dc_link_ctrl_config;
  logic [7:0] ride_through_activation_pct;
  logic [15:0] nominal_supply_voltage;
  logic [15:0] ride_through_max_duration;
  logic [15:0] ride_through_speed_threshold;
  logic [15:0] ride_through_activation_volts;
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] irq_mask;
  logic [NUM_EV-1:0] event_set;
  logic [15:0] hold_cnt;
  logic [15:0] fb_cnt;
  logic [15:0] rt_cnt;
  logic contactor_drive_signal;
  logic drive_q;
  logic run_s, sto_s, fb_pin_s;
  logic inverted_digital_input;
  logic fb_seen;
  logic ms_tick;
  logic rt_active;
  logic rt_enable;
  logic dur_fault_q, spd_fault_q;

  typedef enum {CS_OPEN, CS_CLOSED, CS_HOLD} cdr_cstate_e;
  cdr_cstate_e cstate;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  cdr_ms_tick u_tick (
    .clk(CLOCK),
    .rst(RST),
    .tick(ms_tick)
  );

  // Pins are asynchronous to CLOCK
  cdr_sync2 #(.W(3)) u_sync (
    .clk(CLOCK),
    .rst(RST),
    .d({RUN_REQ, SAFE_TORQUE_OFF, CONTACTOR_FEEDBACK_PIN}),
    .q({run_s, sto_s, fb_pin_s})
  );

  // Contact closed pulls the input low, so the used sense is inverted
  assign inverted_digital_input = ~fb_pin_s;
  assign fb_seen = contactor_feedback_source ? inverted_digital_input : contactor_drive_signal;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Configuration registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      contactor_feedback_source <= 1'b0;
      sequence_config <= 1'b0;
      contactor_feedback_timeout <= RST_FB_TIMEOUT;
      contactor_holding_delay <= RST_HOLD_DELAY;
      dc_link_ctrl_config <= RST_DC_CFG;
      ride_through_activation_pct <= RST_ACT_PCT;
      nominal_supply_voltage <= RST_NOM_VOLTS;
      RIDE_THROUGH_DYN_FACTOR <= RST_DYN_FACTOR;
      ride_through_max_duration <= RST_MAX_DUR_MS;
      ride_through_speed_threshold <= RST_SPEED_THR;
      irq_mask <= '0;
    end else if (WR) begin
      unique case (ADDR)
        REG_CTRL: begin
          contactor_feedback_source <= WDATA[CTRL_FB_SRC];
          sequence_config <= WDATA[CTRL_SEQ_CFG];
        end
        REG_FB_TIMEOUT: contactor_feedback_timeout <= WDATA[15:0];
        REG_HOLD_DELAY: contactor_holding_delay <= WDATA[15:0];
        REG_DC_CFG: dc_link_ctrl_config <= WDATA[1:0];
        REG_ACT_PCT: ride_through_activation_pct <= WDATA[7:0];
        REG_NOM_VOLTS: nominal_supply_voltage <= WDATA[15:0];
        REG_DYN_FACTOR: RIDE_THROUGH_DYN_FACTOR <= WDATA[15:0];
        REG_MAX_DUR: ride_through_max_duration <= WDATA[15:0];
        REG_SPEED_THR: ride_through_speed_threshold <= WDATA[15:0];
        REG_IRQ_MASK: irq_mask <= WDATA[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Activation voltage
  // ----------------------------------------
  // pct x root2 x nominal; registered to keep the multiplier path short
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ride_through_activation_volts <= '0;
    end else begin
      ride_through_activation_volts <= 16'(((35'(ride_through_activation_pct) *
        35'(SQRT2_Q10) * 35'(nominal_supply_voltage)) >> 10) / 35'(PCT_DIV));
    end
  end

  // ----------------------------------------
  // Contactor sequence
  // ----------------------------------------
  // close on run, open after hold
  // hold delay or immediate open on safe torque off
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cstate <= CS_OPEN;
      hold_cnt <= '0;
    end else begin
      unique case (cstate)
        CS_OPEN: begin
          if (run_s && !sto_s) begin
            cstate <= CS_CLOSED;
          end
        end
        CS_CLOSED: begin
          hold_cnt <= '0;
          if (sto_s && !sequence_config) begin
            cstate <= CS_OPEN;
          end else if (!run_s || sto_s) begin
            cstate <= CS_HOLD;
          end
        end
        CS_HOLD: begin
          if (sto_s && !sequence_config) begin
            cstate <= CS_OPEN;
          end else if (run_s && !sto_s) begin
            cstate <= CS_CLOSED;
          end else if (hold_cnt >= contactor_holding_delay) begin
            cstate <= CS_OPEN;
          end else if (ms_tick) begin
            hold_cnt <= hold_cnt + 16'h1;
          end
        end
      endcase
    end
  end

  assign contactor_drive_signal = (cstate != CS_OPEN);

  // Drive output straight from a flip-flop
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CONTACTOR_DRIVE <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      CONTACTOR_DRIVE <= contactor_drive_signal;
      drive_q <= contactor_drive_signal;
    end
  end

  // ----------------------------------------
  // Feedback supervision
  // ----------------------------------------
  // timer restarts on every command change
  // timeout when feedback has not followed
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fb_cnt <= '0;
    end else if (drive_q != contactor_drive_signal || fb_seen == drive_q) begin
      fb_cnt <= '0;
    end else if (ms_tick && fb_cnt != 16'hffff) begin
      fb_cnt <= fb_cnt + 16'h1;
    end
  end

  assign event_set[EV_FB_FAULT] = (fb_seen != drive_q) &&
    (drive_q == contactor_drive_signal) && (fb_cnt >= contactor_feedback_timeout) &&
    (fb_cnt != 16'h0 || contactor_feedback_timeout == 16'h0);

  // ----------------------------------------
  // Ride-through
  // ----------------------------------------
  // minimum control codes
  assign rt_enable = (dc_link_ctrl_config == DC_MIN_ONLY) || (dc_link_ctrl_config == DC_BOTH);

  // leave at once on line return
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rt_active <= 1'b0;
    end else begin
      rt_active <= rt_enable && contactor_drive_signal &&
        (DC_LINK_VOLTS <= ride_through_activation_volts);
    end
  end

  // Duration counter in ms; saturates so a long dip never wraps
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rt_cnt <= '0;
    end else if (!rt_active) begin
      rt_cnt <= '0;
    end else if (ms_tick && rt_cnt != 16'hffff) begin
      rt_cnt <= rt_cnt + 16'h1;
    end
  end

  assign event_set[EV_DUR_FAULT] = rt_active && (ride_through_max_duration != 16'h0) &&
    (rt_cnt > ride_through_max_duration);
  assign event_set[EV_SPD_FAULT] = rt_active && (MOTOR_SPEED < ride_through_speed_threshold);
  assign event_set[EV_RT_ENTER] = !rt_active && rt_enable && contactor_drive_signal &&
    (DC_LINK_VOLTS <= ride_through_activation_volts);

  // Status and ride-through output
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RIDE_THROUGH_ACTIVE <= 1'b0;
    end else begin
      RIDE_THROUGH_ACTIVE <= rt_active;
    end
  end

  // ----------------------------------------
  // Sticky faults and interrupt
  // ----------------------------------------
  // latched until acked; set wins over clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_status <= '0;
    end else if (WR && ADDR == REG_IRQ_STATUS) begin
      irq_status <= (irq_status & ~WDATA[NUM_EV-1:0]) | event_set;
    end else begin
      irq_status <= irq_status | event_set;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // One cycle read latency; unmapped reads zero
  always_ff @(posedge CLOCK) begin
    if (RST || !RD) begin
      RDATA <= '0;
    end else begin
      unique case (ADDR)
        REG_CTRL: RDATA <= {30'h0, sequence_config, contactor_feedback_source};
        REG_FB_TIMEOUT: RDATA <= {16'h0, contactor_feedback_timeout};
        REG_HOLD_DELAY: RDATA <= {16'h0, contactor_holding_delay};
        REG_DC_CFG: RDATA <= {30'h0, dc_link_ctrl_config};
        REG_ACT_PCT: RDATA <= {24'h0, ride_through_activation_pct};
        REG_NOM_VOLTS: RDATA <= {16'h0, nominal_supply_voltage};
        REG_DYN_FACTOR: RDATA <= {16'h0, RIDE_THROUGH_DYN_FACTOR};
        REG_MAX_DUR: RDATA <= {16'h0, ride_through_max_duration};
        REG_SPEED_THR: RDATA <= {16'h0, ride_through_speed_threshold};
        REG_ACT_VOLTS: RDATA <= {16'h0, ride_through_activation_volts};
        REG_STATUS_WORD: RDATA <= {16'h0, rt_active, 14'h0, contactor_drive_signal};
        REG_IRQ_STATUS: RDATA <= {28'h0, irq_status};
        REG_IRQ_MASK: RDATA <= {28'h0, irq_mask};
        default: RDATA <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_sto_immediate;
    cstate != CS_OPEN && sto_s && !sequence_config;
  endsequence

  a_sto_opens_now: assert property (@(posedge CLOCK) disable iff (RST)
    s_sto_immediate |=> cstate == CS_OPEN ##1 !CONTACTOR_DRIVE)
    else $error("contactor not opened at once on safe torque off");

  a_drive_follows: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(contactor_drive_signal) |=> CONTACTOR_DRIVE)
    else $error("drive output lags the sequence");

  a_hold_no_early: assert property (@(posedge CLOCK) disable iff (RST)
    cstate == CS_HOLD && hold_cnt < contactor_holding_delay && !(sto_s && !sequence_config)
    && !run_s |=> cstate != CS_OPEN)
    else $error("contactor opened before holding delay");

  a_loopback_quiet: assert property (@(posedge CLOCK) disable iff (RST)
    !contactor_feedback_source && drive_q == contactor_drive_signal |-> !event_set[EV_FB_FAULT])
    else $error("loopback feedback raised a fault");

  a_fault_sticky: assert property (@(posedge CLOCK) disable iff (RST)
    irq_status[EV_FB_FAULT] && !(WR && ADDR == REG_IRQ_STATUS) |=> irq_status[EV_FB_FAULT])
    else $error("fault cleared without acknowledge");

  a_fault_latch: assert property (@(posedge CLOCK) disable iff (RST)
    event_set[EV_FB_FAULT] |=> irq_status[EV_FB_FAULT])
    else $error("feedback fault not latched");

  a_rt_leave: assert property (@(posedge CLOCK) disable iff (RST)
    rt_active && DC_LINK_VOLTS > ride_through_activation_volts |=> !rt_active)
    else $error("ride-through held after line return");

  a_rt_inhibit: assert property (@(posedge CLOCK) disable iff (RST)
    !rt_enable |=> !rt_active)
    else $error("ride-through active while inhibited");

  a_dur_disabled: assert property (@(posedge CLOCK) disable iff (RST)
    ride_through_max_duration == 16'h0 |-> !event_set[EV_DUR_FAULT])
    else $error("duration fault with check disabled");

  a_speed_fault: assert property (@(posedge CLOCK) disable iff (RST)
    rt_active && MOTOR_SPEED < ride_through_speed_threshold |=> irq_status[EV_SPD_FAULT])
    else $error("speed fault missed");

  a_status_bit: assert property (@(posedge CLOCK) disable iff (RST)
    RD && ADDR == REG_STATUS_WORD |=> RDATA[RT_ACTIVE_BIT] == $past(rt_active))
    else $error("status bit 15 wrong");
endmodule
`default_nettype wire

// ### test/cdr_contactor_model.sv
// Line contactor model: coil drive in, auxiliary feedback contact out.
// Assumes the contact pulls the feedback pin low while the main contacts are closed.
`default_nettype none
module cdr_contactor_model #(
  parameter int DELAY = 3
) (
  // Clock
  input wire logic clk,
  // Coil and contact
  input wire logic coil,
  output logic contact_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Armature travel
  // ----------------------------------------
  logic [DELAY-1:0] travel = '0;

  // Mechanical lag, so the block never sees the contact move with the coil
  always @(posedge clk) begin
    travel <= {travel[DELAY-2:0], coil};
  end

  // Auxiliary contact is low while closed
  assign contact_n = ~travel[DELAY-1];
endmodule
`default_nettype wire

// ### test/cdr_top_test.sv
// Self-checking bench for the contactor and ride-through block.
// Assumes the design under rtl/ and the contactor model under test/.
`default_nettype none
module cdr_top_test
  import cdr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic run_req;
  logic torque_off;
  logic drive;
  logic fb_n;
  logic [15:0] dc_volts;
  logic [15:0] speed;
  logic rt_active;
  logic [15:0] dyn;
  logic irq;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] act;

  // 125 MHz clock
  always #4 clk = ~clk;

  // Design and far-side contactor
  cdr_top cdr_top_i (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RUN_REQ(run_req), .SAFE_TORQUE_OFF(torque_off), .CONTACTOR_DRIVE(drive),
    .CONTACTOR_FEEDBACK_PIN(fb_n), .DC_LINK_VOLTS(dc_volts), .MOTOR_SPEED(speed),
    .RIDE_THROUGH_ACTIVE(rt_active), .RIDE_THROUGH_DYN_FACTOR(dyn), .IRQ(irq));
  cdr_contactor_model #(.DELAY(4)) cdr_contactor_model_i (.clk(clk), .coil(drive),
    .contact_n(fb_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Edges then a settle step, so checks never race the design
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask

  // Bounded wait; a bound used up ends the run
  task automatic wait_drive(input logic val, input int bound, input string name);
    int n;
    n = 0;
    while (drive !== val && n < bound) begin
      cyc(1);
      n++;
    end
    check(name, {31'h0, drive}, {31'h0, val});
    if (n >= bound) begin
      print_verdict();
    end
  endtask

  // Threshold with root two taken as 1448/1024
  function automatic logic [31:0] act_of(input logic [31:0] pct, input logic [31:0] nom);
    return ((pct * 32'h5a8 * nom) >> 10) / 32'h64;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    act = act_of(32'h4c, 32'h190);
    rd_chk("feedback timeout", REG_FB_TIMEOUT, 32'h64);
    rd_chk("holding delay", REG_HOLD_DELAY, 32'h32);
    rd_chk("dc config", REG_DC_CFG, 32'h1);
    rd_chk("activation pct", REG_ACT_PCT, 32'h4c);
    rd_chk("nominal volts", REG_NOM_VOLTS, 32'h190);
    rd_chk("activation volts", REG_ACT_VOLTS, act);
    rd_chk("dynamic factor", REG_DYN_FACTOR, 32'h12c);
    rd_chk("max duration", REG_MAX_DUR, 32'h0);
    rd_chk("speed threshold", REG_SPEED_THR, 32'h32);
    rd_chk("control", REG_CTRL, 32'h0);
    rd_chk("unmapped", 8'h3c, 32'h0);
    check("dyn factor port", {16'h0, dyn}, 32'h12c);
    wr_reg(REG_ACT_PCT, 32'h50);
    rd_chk("activation volts 80", REG_ACT_VOLTS, act_of(32'h50, 32'h190));
    wr_reg(REG_ACT_PCT, 32'h4c);
  endtask

  task automatic t_close();
    @(posedge clk);
    run_req <= 1'b1;
    wait_drive(1'b1, 8, "drive close");
    rd_chk("status drive", REG_STATUS_WORD, 32'h1);
  endtask

  task automatic t_torque_off();
    @(posedge clk);
    torque_off <= 1'b1;
    wait_drive(1'b0, 6, "torque off immediate");
    @(posedge clk);
    torque_off <= 1'b0;
    wait_drive(1'b1, 8, "reclose");
    wr_reg(REG_HOLD_DELAY, 32'h1);
    wr_reg(REG_CTRL, 32'h2);
    @(posedge clk);
    torque_off <= 1'b1;
    cyc(1000);
    check("torque off delayed", {31'h0, drive}, 32'h1);
    @(posedge clk);
    torque_off <= 1'b0;
    wait_drive(1'b1, 260000, "after torque off");
    wr_reg(REG_CTRL, 32'h0);
  endtask

  task automatic t_ride();
    // Every controller configuration, minimum enabled only in 2 and 3
    for (int c = 0; c < 4; c++) begin
      wr_reg(REG_DC_CFG, 32'(c));
      @(posedge clk);
      dc_volts <= act[15:0];
      cyc(3);
      check("rt by config", {31'h0, rt_active}, 32'(c >> 1));
      @(posedge clk);
      dc_volts <= 16'h0250;
      cyc(3);
      check("rt leave", {31'h0, rt_active}, 32'h0);
    end
    wr_reg(REG_IRQ_STATUS, 32'hf);
    wr_reg(REG_IRQ_MASK, 32'h8);
    @(posedge clk);
    dc_volts <= act[15:0] + 16'h1;
    cyc(3);
    check("rt above", {31'h0, rt_active}, 32'h0);
    @(posedge clk);
    dc_volts <= act[15:0];
    cyc(2);
    check("rt engage", {31'h0, rt_active}, 32'h1);
    rd_chk("status rt", REG_STATUS_WORD, 32'h8001);
    check("irq raised", {31'h0, irq}, 32'h1);
    @(posedge clk);
    speed <= 16'h32;
    cyc(3);
    rd_chk("speed at threshold", REG_IRQ_STATUS, 32'h8);
    @(posedge clk);
    speed <= 16'h31;
    cyc(3);
    rd_chk("speed fault", REG_IRQ_STATUS, 32'hc);
    @(posedge clk);
    speed <= 16'h100;
    dc_volts <= 16'h0250;
    cyc(2);
    check("rt line back", {31'h0, rt_active}, 32'h0);
    rd_chk("faults latched", REG_IRQ_STATUS, 32'hc);
    wr_reg(REG_IRQ_STATUS, 32'h4);
    rd_chk("partial clear", REG_IRQ_STATUS, 32'h8);
    wr_reg(REG_IRQ_STATUS, 32'h8);
    cyc(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_ramp_stop();
    wr_reg(REG_CTRL, 32'h1);
    wr_reg(REG_HOLD_DELAY, 32'h1);
    @(posedge clk);
    run_req <= 1'b0;
    cyc(1000);
    check("hold closed", {31'h0, drive}, 32'h1);
    @(posedge clk);
    run_req <= 1'b1;
    cyc(10);
    check("run again", {31'h0, drive}, 32'h1);
    wr_reg(REG_HOLD_DELAY, 32'h0);
    @(posedge clk);
    run_req <= 1'b0;
    wait_drive(1'b0, 260000, "open after hold");
    cyc(10);
    rd_chk("feedback followed", REG_IRQ_STATUS, 32'h0);
    // Zero monitoring time: the contact's travel lag must trip supervision
    wr_reg(REG_FB_TIMEOUT, 32'h0);
    @(posedge clk);
    run_req <= 1'b1;
    wait_drive(1'b1, 8, "close supervised");
    cyc(10);
    rd_chk("feedback lag fault", REG_IRQ_STATUS, 32'h1);
    wr_reg(REG_IRQ_STATUS, 32'h1);
    rd_chk("feedback fault acked", REG_IRQ_STATUS, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    run_req = 1'b0;
    torque_off = 1'b0;
    dc_volts = 16'h0250;
    speed = 16'h0100;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_close();
    t_torque_off();
    t_ride();
    t_ramp_stop();
    print_verdict();
  end
endmodule
`default_nettype wire
